// *** rtl/instruction_driven_watchdog.sv ***
// Purpose: Watchdog steered by opcodes executed in the core
// Assumes: One opcode strobe per executed instruction, inputs synchronous to mclk_i
// Notes:   Register port offers status, mask and a live view of the count
//
// Overview of operation
// - First refresh opcode enables the watchdog
// - Later refresh opcodes clear the counter
// - No instruction can stop an enabled watchdog
// - Missing refresh within period asserts reset
// - Timeout reset lasts power on interval plus 18
// - Refresh sets zero flag, clears sign, overflow
// - Software watchdog pauses in stopped state
// - Halt-run opcode lets counting continue in halt
// - Halt-run opcode leaves the count unchanged
// - Halt-run opcode ignored before watchdog enabled
// - Permanent option enables watchdog leaving reset
// - Permanent watchdog runs in halt and stop
// - Pin recovery jumps to recovery address, keeps ports
//
// The strobed register port and the register offsets were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module instruction_driven_watchdog
	import watchdog_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = WDT_PERIOD_CYCLES,
	parameter int unsigned POR_CYCLES     = POR_INTERVAL_CYCLES
) (
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	// Opcode strobe from the core
	input  wire logic              op_exec_i,
	input  wire logic [7:0]        op_code_i,
	// Power states and option strap
	input  wire logic              halt_mode_i,
	input  wire logic              stop_mode_i,
	input  wire logic              permanent_opt_i,
	input  wire logic              stop_recovery_pin_n_i,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	// Results
	output logic                   wdt_reset_o,
	output logic                   flag_we_o,
	output flags_t                 flags_o,
	output logic                   resume_o,
	output logic      [15:0]       resume_addr_o,
	output logic                   port_defaults_o,
	output logic                   irq_o
);

	localparam int unsigned STRETCH_CYCLES = POR_CYCLES + CRYSTAL_EXTRA_CYCLES;
	localparam int unsigned WD_W           = $clog2(TIMEOUT_CYCLES + 1);
	localparam int unsigned ST_W           = $clog2(STRETCH_CYCLES + 1);

	// Picks one byte of the count for the register port
	function automatic logic [DATA_W-1:0] count_byte(input logic [23:0] c, input int unsigned idx);
		logic [23:0] sh;
		sh = c >> (idx * DATA_W);
		return sh[DATA_W-1:0];
	endfunction : count_byte

	// Watchdog state
	wd_state_t         state_q, state_d;     // Main state
	logic              perm_q, perm_d;       // Permanent option caught after reset
	logic              hrun_q, hrun_d;       // Halt-run permission
	logic              rst_out_q, rst_out_d; // Reset to the device
	logic              port_def_q, port_def_d; // Port defaults restore pulse

	// Decoded opcodes, only while the device is out of reset
	logic              refresh_op;
	logic              hrun_op;
	logic              wd_run;               // Watchdog may count
	logic              wd_clear;             // Counter back to zero
	logic              wd_expire;            // Period ran out
	logic [WD_W-1:0]   wd_count;             // Watchdog count
	logic              st_done;              // Reset stretch over

	assign refresh_op = op_exec_i && (op_code_i == OP_REFRESH) && (state_q != WD_RESET) && (state_q != WD_STRAP);
	assign hrun_op    = op_exec_i && (op_code_i == OP_HALT_RUN) && (state_q != WD_RESET) && (state_q != WD_STRAP);

	// Counting gate; permanent ignores both low power states
	always_comb begin
		wd_run = 1'b0;
		if (state_q == WD_ON) begin
			if (perm_q) begin
				wd_run = 1'b1;
			end else begin
				wd_run = !stop_mode_i && (!halt_mode_i || hrun_q);
			end
		end
	end

	// Clear on refresh, and hold at zero while not armed
	assign wd_clear = (state_q != WD_ON) || refresh_op;

	// Period counter, length set by a parameter
	wdt_counter #(
		.LIMIT (TIMEOUT_CYCLES),
		.WIDTH (WD_W)
	) u_wd_count (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (wd_clear),
		.run_i     (wd_run),
		.count_o   (wd_count),
		.done_o    (wd_expire)
	);

	// Reset stretch; one less because the pulse lags by a cycle
	wdt_counter #(
		.LIMIT (STRETCH_CYCLES - 1),
		.WIDTH (ST_W)
	) u_stretch (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (state_q != WD_RESET),
		.run_i     (state_q == WD_RESET),
		.count_o   (),
		.done_o    (st_done)
	);

	// Next state; nothing but a timeout or reset leaves the armed state
	always_comb begin
		state_d    = state_q;
		perm_d     = perm_q;
		hrun_d     = hrun_q;
		port_def_d = 1'b0;
		unique case (state_q)
			WD_STRAP: begin
				// Strap caught one cycle after release, never under reset
				perm_d     = permanent_opt_i;
				state_d    = permanent_opt_i ? WD_ON : WD_OFF;
				port_def_d = 1'b1;
			end
			WD_OFF: begin
				if (refresh_op) begin
					state_d = WD_ON;
				end
			end
			WD_ON: begin
				if (hrun_op) begin
					hrun_d = 1'b1;
				end
				if (wd_expire) begin
					state_d = WD_RESET;
				end
			end
			WD_RESET: begin
				hrun_d = 1'b0;
				if (st_done) begin
					// Behaves like power on: permanent comes back armed
					state_d    = perm_q ? WD_ON : WD_OFF;
					port_def_d = 1'b1;
				end
			end
		endcase
		rst_out_d = (state_d == WD_RESET);
	end

	// Watchdog registers
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state_q    <= WD_STRAP;
			perm_q     <= 1'b0;
			hrun_q     <= 1'b0;
			rst_out_q  <= 1'b0;
			port_def_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			perm_q     <= perm_d;
			hrun_q     <= hrun_d;
			rst_out_q  <= rst_out_d;
			port_def_q <= port_def_d;
		end
	end

	// Flag update from a refresh
	logic   flag_we_q, flag_we_d; // Flag write pulse
	flags_t flags_q, flags_d;     // Flag values
	always_comb begin
		flag_we_d = refresh_op;
		flags_d   = refresh_op ? FLAGS_AFTER_REFRESH : flags_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			flag_we_q <= 1'b0;
			flags_q   <= FLAGS_RST;
		end else begin
			flag_we_q <= flag_we_d;
			flags_q   <= flags_d;
		end
	end

	// Stop recovery by pin; one pulse per stop period, at the first low level seen in it
	logic        wake_busy_q, wake_busy_d; // Pin wake already taken
	logic        resume_q, resume_d;       // Resume pulse
	logic [15:0] resume_addr_q, resume_addr_d;
	logic        pin_wake;                 // Fresh pin wake

	assign pin_wake = stop_mode_i && !stop_recovery_pin_n_i && !wake_busy_q;

	always_comb begin
		wake_busy_d   = stop_mode_i && (wake_busy_q || !stop_recovery_pin_n_i);
		resume_d      = pin_wake;
		resume_addr_d = pin_wake ? RECOVERY_ADDR : resume_addr_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			wake_busy_q   <= 1'b0;
			resume_q      <= 1'b0;
			resume_addr_q <= 16'h0000;
		end else begin
			wake_busy_q   <= wake_busy_d;
			resume_q      <= resume_d;
			resume_addr_q <= resume_addr_d;
		end
	end

	// Register port: sticky events, mask, read data
	logic [EVT_W-1:0]  status_q, status_d; // Sticky events
	logic [EVT_W-1:0]  mask_q, mask_d;     // Interrupt mask
	logic [DATA_W-1:0] rdata_q, rdata_d;   // Read data, one cycle late
	logic              irq_q, irq_d;       // Interrupt level
	logic [EVT_W-1:0]  events;             // Events this cycle
	logic [DATA_W-1:0] ctrl_view;          // Control register image

	always_comb begin
		events                  = '0;
		events[EVT_TIMEOUT_BIT] = wd_expire;
		events[EVT_REFRESH_BIT] = refresh_op;
		events[EVT_RECOVER_BIT] = pin_wake;
		ctrl_view                = '0;
		ctrl_view[CTRL_EN_BIT]   = (state_q == WD_ON);
		ctrl_view[CTRL_HRUN_BIT] = hrun_q;
		ctrl_view[CTRL_PERM_BIT] = perm_q;
		ctrl_view[CTRL_RST_BIT]  = rst_out_q;
	end

	// Next register values; a set in the clearing cycle survives
	always_comb begin
		status_d = status_q;
		mask_d   = mask_q;
		rdata_d  = '0;
		if (reg_wr_i && (reg_addr_i == REG_STATUS)) begin
			status_d = status_q & ~reg_wdata_i[EVT_W-1:0];
		end
		status_d = status_d | events;
		if (reg_wr_i && (reg_addr_i == REG_MASK)) begin
			mask_d = reg_wdata_i[EVT_W-1:0];
		end
		// Writes to the control image are dropped: it cannot stop the dog
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CTRL:   rdata_d = ctrl_view;
				REG_STATUS: rdata_d = DATA_W'(status_q);
				REG_MASK:   rdata_d = DATA_W'(mask_q);
				REG_COUNT0: rdata_d = count_byte(24'(wd_count), 0);
				REG_COUNT1: rdata_d = count_byte(24'(wd_count), 1);
				REG_COUNT2: rdata_d = count_byte(24'(wd_count), 2);
				default:    rdata_d = '0;
			endcase
		end
		irq_d = |(status_d & mask_d);
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			status_q <= STATUS_RST;
			mask_q   <= MASK_RST;
			rdata_q  <= '0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			mask_q   <= mask_d;
			rdata_q  <= rdata_d;
			irq_q    <= irq_d;
		end
	end

	// Outputs straight from flops
	assign reg_rdata_o     = rdata_q;
	assign wdt_reset_o     = rst_out_q;
	assign flag_we_o       = flag_we_q;
	assign flags_o         = flags_q;
	assign resume_o        = resume_q;
	assign resume_addr_o   = resume_addr_q;
	assign port_defaults_o = port_def_q;
	assign irq_o           = irq_q;

	// Checks
	int unsigned rst_len_q; // Length of the current reset pulse
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			rst_len_q <= 0;
		end else begin
			rst_len_q <= rst_out_q ? rst_len_q + 1 : 0;
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_refresh_taken;
		refresh_op ##1 flag_we_q;
	endsequence
	sequence s_pin_wake;
		stop_mode_i && !stop_recovery_pin_n_i && !wake_busy_q;
	endsequence

	property p_enable_on_refresh;
		(state_q == WD_OFF) && refresh_op |=> (state_q == WD_ON) && (wd_count == '0);
	endproperty
	a_enable_on_refresh: assert property (p_enable_on_refresh) else $error("refresh did not enable");
	property p_refresh_clears;
		(state_q == WD_ON) && refresh_op && !wd_expire |=> (wd_count == '0) && (state_q == WD_ON);
	endproperty
	a_refresh_clears: assert property (p_refresh_clears) else $error("refresh did not clear count");
	property p_no_stop;
		(state_q == WD_ON) && !wd_expire |=> (state_q == WD_ON);
	endproperty
	a_no_stop: assert property (p_no_stop) else $error("watchdog left enabled state");
	property p_timeout_reset;
		wd_expire |=> rst_out_q ##1 rst_out_q;
	endproperty
	a_timeout_reset: assert property (p_timeout_reset) else $error("timeout gave no reset");
	property p_reset_length;
		$fell(rst_out_q) |-> ($past(rst_len_q) == STRETCH_CYCLES - 1);
	endproperty
	a_reset_length: assert property (p_reset_length) else $error("reset pulse length wrong");
	property p_flags;
		s_refresh_taken |-> (flags_q == FLAGS_AFTER_REFRESH);
	endproperty
	a_flags: assert property (p_flags) else $error("flags after refresh wrong");
	property p_stop_pause;
		(state_q == WD_ON) && !perm_q && stop_mode_i && !refresh_op |=> $stable(wd_count);
	endproperty
	a_stop_pause: assert property (p_stop_pause) else $error("count moved in stop");
	property p_halt_pause;
		(state_q == WD_ON) && !perm_q && halt_mode_i && !hrun_q && !refresh_op |=> $stable(wd_count);
	endproperty
	a_halt_pause: assert property (p_halt_pause) else $error("count moved in halt");
	property p_hrun_keeps_count;
		(state_q == WD_ON) && hrun_op && !refresh_op && (wd_count != '0) && !wd_expire
			&& (wd_count != WD_W'(TIMEOUT_CYCLES - 1)) |=> (wd_count != '0);
	endproperty
	a_hrun_keeps_count: assert property (p_hrun_keeps_count) else $error("halt-run cleared count");
	property p_hrun_ignored;
		(state_q == WD_OFF) && !hrun_q && hrun_op |=> !hrun_q;
	endproperty
	a_hrun_ignored: assert property (p_hrun_ignored) else $error("halt-run took effect while off");
	property p_perm_start;
		(state_q == WD_STRAP) && permanent_opt_i |=> (state_q == WD_ON) && perm_q;
	endproperty
	a_perm_start: assert property (p_perm_start) else $error("permanent option did not arm");
	property p_perm_runs;
		(state_q == WD_ON) && perm_q && (stop_mode_i || halt_mode_i) && !refresh_op |=> !$stable(wd_count);
	endproperty
	a_perm_runs: assert property (p_perm_runs) else $error("permanent watchdog paused");
	property p_recovery;
		s_pin_wake |=> resume_q && (resume_addr_q == RECOVERY_ADDR) && !port_defaults_o;
	endproperty
	a_recovery: assert property (p_recovery) else $error("pin recovery wrong");

endmodule : instruction_driven_watchdog

`default_nettype wire

// *** common/watchdog_pkg.sv ***
// Purpose: Shared constants and types for the instruction driven watchdog
// Assumes: Device clock of 25 MHz, the crystal clock and the device clock are the same
// Notes:   Times are kept in their own unit, cycle counts derive from them

package watchdog_pkg;

	// Clock
	localparam int unsigned CLK_PERIOD_NS        = 40;

	// Watchdog period; longest time, so it rounds down
	localparam int unsigned WDT_PERIOD_US        = 5000;
	localparam int unsigned WDT_PERIOD_CYCLES    = (WDT_PERIOD_US * 1000) / CLK_PERIOD_NS;

	// Power on reset interval; least time, so it rounds up
	localparam int unsigned POR_INTERVAL_US      = 10000;
	localparam int unsigned POR_INTERVAL_CYCLES  = (POR_INTERVAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Extra crystal clocks added after the power on reset interval
	localparam int unsigned CRYSTAL_EXTRA_CYCLES = 18;

	// Opcodes seen from the core
	localparam logic [7:0]  OP_REFRESH           = 8'h5F;
	localparam logic [7:0]  OP_HALT_RUN          = 8'h4F;

	// Program address taken after pin recovery from the stopped state
	localparam logic [15:0] RECOVERY_ADDR        = 16'h000C;

	// Register port
	localparam int unsigned ADDR_W               = 4;
	localparam int unsigned DATA_W               = 8;
	localparam logic [3:0]  REG_CTRL             = 4'h0;
	localparam logic [3:0]  REG_STATUS           = 4'h1;
	localparam logic [3:0]  REG_MASK             = 4'h2;
	localparam logic [3:0]  REG_COUNT0           = 4'h3;
	localparam logic [3:0]  REG_COUNT1           = 4'h4;
	localparam logic [3:0]  REG_COUNT2           = 4'h5;

	// Control register fields (read only)
	localparam int unsigned CTRL_EN_BIT          = 0;
	localparam int unsigned CTRL_HRUN_BIT        = 1;
	localparam int unsigned CTRL_PERM_BIT        = 2;
	localparam int unsigned CTRL_RST_BIT         = 3;

	// Status and mask fields
	localparam int unsigned EVT_W                = 3;
	localparam int unsigned EVT_TIMEOUT_BIT      = 0;
	localparam int unsigned EVT_REFRESH_BIT      = 1;
	localparam int unsigned EVT_RECOVER_BIT      = 2;
	localparam logic [2:0]  STATUS_RST           = 3'h0;
	localparam logic [2:0]  MASK_RST             = 3'h0;

	// Core flag group written by a refresh
	typedef struct packed {
		logic z;
		logic s;
		logic v;
	} flags_t;
	localparam flags_t      FLAGS_RST            = 3'h0;
	localparam flags_t      FLAGS_AFTER_REFRESH  = 3'h4;

	// Watchdog states
	typedef enum logic [1:0] {
		WD_STRAP,
		WD_OFF,
		WD_ON,
		WD_RESET
	} wd_state_t;

endpackage : watchdog_pkg

// *** rtl/wdt_counter.sv ***
// Purpose: Up counter with clear, run and a terminal pulse
// Assumes: LIMIT of at least two
// Notes:   The pulse comes one cycle after the count hits LIMIT-1

`timescale 1ns/1ps
`default_nettype none

module wdt_counter #(
	parameter int unsigned LIMIT = 16,
	parameter int unsigned WIDTH = $clog2(LIMIT + 1)
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	input  wire logic             clear_i,
	input  wire logic             run_i,
	output logic      [WIDTH-1:0] count_o,
	output logic                  done_o
);

	logic [WIDTH-1:0] count_q, count_d; // Running count
	logic             done_q, done_d;   // Terminal pulse
	logic             hit;              // Last count reached

	// Next count; clear wins over run
	always_comb begin
		hit     = (count_q == WIDTH'(LIMIT - 1));
		count_d = count_q;
		done_d  = 1'b0;
		if (clear_i) begin
			count_d = '0;
		end else if (run_i) begin
			count_d = hit ? '0 : count_q + WIDTH'(1);
			done_d  = hit;
		end
	end

	// Registers only
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			count_q <= '0;
			done_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q  <= done_d;
		end
	end

	assign count_o = count_q;
	assign done_o  = done_q;

endmodule : wdt_counter

`default_nettype wire

// *** testbench/core_model.sv ***
// Purpose: Behavioural core that executes watchdog opcodes on command
// Assumes: One opcode per request, issued by the bench at a rising edge
// Notes:   The opcode bus carries a changing pattern between instructions

`timescale 1ns/1ps
`default_nettype none

module core_model (
	input  wire logic       mclk_i,
	input  wire logic       issue_i,
	input  wire logic [7:0] code_i,
	output logic            op_exec_o,
	output logic      [7:0] op_code_o
);
	// Known levels before the first edge
	initial begin
		op_exec_o = 1'b0;
		op_code_o = 8'h00;
	end

	// One strobe per executed instruction; refresh cadence is up to the caller
	always @(posedge mclk_i) begin
		op_exec_o <= issue_i;
		// Idle bus toggles, so the stale opcode comes back every other cycle; only the strobe marks a fresh one
		op_code_o <= issue_i ? code_i : ~op_code_o;
	end
endmodule : core_model

`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the instruction driven watchdog
// Assumes: Shortened timeout and reset interval, one clock domain
// Notes:   Register reads are checked by a monitor against a queue of notes

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import watchdog_pkg::*;
	localparam int unsigned T = 20;       // Shortened timeout
	localparam int unsigned P = 10;       // Shortened reset interval
	logic              mclk_i    = 1'b0;
	logic              reset_n_i = 1'b0;
	logic              issue     = 1'b0;  // Request to the core model
	logic        [7:0] code      = 8'h00;
	logic              op_exec;
	logic        [7:0] op_code;
	logic              halt      = 1'b0;
	logic              stop      = 1'b0;
	logic              perm      = 1'b0;
	logic              pin_n     = 1'b1;
	logic [ADDR_W-1:0] addr      = '0;
	logic [DATA_W-1:0] wdata     = '0;
	logic              wr        = 1'b0;
	logic              rd        = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic              wd_rst;
	logic              flag_we;
	flags_t            flags;
	logic              resume;
	logic       [15:0] res_addr;
	logic              port_def;
	logic              irq;
	int                num_errors  = 0;
	int                check_count = 0;
	logic       [15:0] rnd = 16'h1084;   // Seed, 4228 decimal
	logic [DATA_W-1:0] exp_q[$];         // Expected read data
	logic [DATA_W-1:0] msk_q[$];         // Bits that matter
	logic              rd_pend = 1'b0;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] b;
	int                n;

	// Free running clock, 40 ns period
	always #20 mclk_i = ~mclk_i;

	core_model CORE (
		.mclk_i    (mclk_i),
		.issue_i   (issue),
		.code_i    (code),
		.op_exec_o (op_exec),
		.op_code_o (op_code)
	);

	instruction_driven_watchdog #(
		.TIMEOUT_CYCLES (T),
		.POR_CYCLES     (P)
	) DUT (
		.mclk_i                (mclk_i),
		.reset_n_i             (reset_n_i),
		.op_exec_i             (op_exec),
		.op_code_i             (op_code),
		.halt_mode_i           (halt),
		.stop_mode_i           (stop),
		.permanent_opt_i       (perm),
		.stop_recovery_pin_n_i (pin_n),
		.reg_addr_i            (addr),
		.reg_wdata_i           (wdata),
		.reg_wr_i              (wr),
		.reg_rd_i              (rd),
		.reg_rdata_o           (rdata),
		.wdt_reset_o           (wd_rst),
		.flag_we_o             (flag_we),
		.flags_o               (flags),
		.resume_o              (resume),
		.resume_addr_o         (res_addr),
		.port_defaults_o       (port_def),
		.irq_o                 (irq)
	);

	// Sixteen bit shift register for opcode noise
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	task automatic finish_test();
		// A note never taken off means a read went unchecked
		if (exp_q.size() != 0) begin
			num_errors++;
			$display("[ERR] %0t read notes left unchecked", $time);
		end
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// Direct comparison of a port value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	// Read data against the oldest note
	task automatic chk_rd(input logic [DATA_W-1:0] got);
		logic [DATA_W-1:0] e;
		logic [DATA_W-1:0] m;
		check_count++;
		if (exp_q.size() == 0) begin
			num_errors++;
			$display("[ERR] %0t read data without a note", $time);
			return;
		end
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		if ((got & m) !== (e & m)) begin
			num_errors++;
			$display("[ERR] %0t read got %0h expected %0h", $time, got, e);
		end
	endtask : chk_rd

	// Monitor: data stands only in the cycle after the strobe
	always @(posedge mclk_i) begin
		if (rd_pend)
			chk_rd(rdata);
		rd_pend = rd;
	end

	task automatic rdreg(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e,
	                     input logic [DATA_W-1:0] m, output logic [DATA_W-1:0] v);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge mclk_i);
		rd   <= 1'b1;
		addr <= ad;
		@(posedge mclk_i);
		rd   <= 1'b0;
		@(negedge mclk_i);
		v = rdata;
	endtask : rdreg

	task automatic wrreg(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		@(posedge mclk_i);
		wr    <= 1'b1;
		addr  <= ad;
		wdata <= d;
		@(posedge mclk_i);
		wr    <= 1'b0;
	endtask : wrreg

	// One instruction through the core; returns as the request drops
	task automatic op(input logic [7:0] c);
		@(posedge mclk_i);
		issue <= 1'b1;
		code  <= c;
		@(posedge mclk_i);
		issue <= 1'b0;
	endtask : op

	// Bounded wait: 0 flag write, 1 watchdog reset, 2 resume
	task automatic wait_hi(input int s, input int lim);
		logic v;
		for (int i = 0; i < lim; i++) begin
			@(negedge mclk_i);
			v = (s == 0) ? flag_we : (s == 1) ? wd_rst : resume;
			if (v === 1'b1)
				return;
		end
		chk(32'h0, 32'h1, "wait ran out");
		finish_test();
	endtask : wait_hi

	// Count cycles of a running watchdog reset
	task automatic reset_len(output int len);
		len = 0;
		while (wd_rst === 1'b1 && len < 200) begin
			@(negedge mclk_i);
			len++;
		end
	endtask : reset_len

	task automatic do_reset(input logic p);
		@(posedge mclk_i);
		reset_n_i <= 1'b0;
		perm      <= p;
		halt      <= 1'b0;
		stop      <= 1'b0;
		repeat (12) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask : do_reset

	initial begin
		do_reset(1'b0);
		rdreg(REG_CTRL, 8'h00, 8'hFF, a);
		rdreg(REG_MASK, 8'h00, 8'hFF, a);
		rdreg(4'hF, 8'h00, 8'hFF, a);
		rdreg(REG_COUNT0, 8'h00, 8'hFF, a);
		rdreg(REG_COUNT1, 8'h00, 8'hFF, a);
		rdreg(REG_COUNT2, 8'h00, 8'hFF, a);
		// Pin recovery from the stopped state
		@(posedge mclk_i);
		stop  <= 1'b1;
		pin_n <= 1'b0;
		wait_hi(2, 8);
		chk(res_addr, RECOVERY_ADDR, "resume address");
		chk(port_def, 1'b0, "port defaults on recovery");
		@(posedge mclk_i);
		stop  <= 1'b0;
		pin_n <= 1'b1;
		rdreg(REG_STATUS, 8'h04, 8'hFF, a);
		wrreg(REG_STATUS, 8'h04);
		$display("test recovery done");
		// Halt-run before enabling, then enable
		op(OP_HALT_RUN);
		repeat (3) @(posedge mclk_i);
		op(OP_REFRESH);
		wait_hi(0, 4);
		chk(flags, FLAGS_AFTER_REFRESH, "flags after refresh");
		rdreg(REG_CTRL, 8'h01, 8'hFF, a);
		// Halt without permission pauses the count
		@(posedge mclk_i);
		halt <= 1'b1;
		rdreg(REG_COUNT0, 8'h00, 8'h00, a);
		rdreg(REG_COUNT0, 8'h00, 8'h00, b);
		chk(b, a, "count moved in halt");
		@(posedge mclk_i);
		halt <= 1'b0;
		stop <= 1'b1;
		rdreg(REG_COUNT0, 8'h00, 8'h00, a);
		op(OP_HALT_RUN);
		repeat (3) @(posedge mclk_i);
		rdreg(REG_COUNT0, 8'h00, 8'h00, b);
		chk(b, a, "count moved in stop or by halt-run");
		@(posedge mclk_i);
		stop <= 1'b0;
		halt <= 1'b1;
		rdreg(REG_COUNT0, 8'h00, 8'h00, a);
		rdreg(REG_COUNT0, 8'h00, 8'h00, b);
		chk(b - a, 32'd2, "count in halt with permission");
		rdreg(REG_CTRL, 8'h03, 8'hFF, a);
		@(posedge mclk_i);
		halt <= 1'b0;
		$display("test low power done");
		// Random opcodes among timely refreshes
		for (n = 0; n < 6; n++) begin
			rnd = lfsr(rnd);
			op(rnd[7:0]);
			op(OP_REFRESH);
			rdreg(REG_COUNT0, 8'h00, 8'h00, a);
			chk(a < 2, 1'b1, "count after refresh");
			repeat (4) @(posedge mclk_i);
		end
		chk(wd_rst, 1'b0, "reset despite refresh");
		rdreg(REG_CTRL, 8'h01, 8'h01, a);
		$display("test refresh done");
		// Missed refresh: timeout reset and interrupt
		wrreg(REG_MASK, 8'h01);
		repeat (2) @(negedge mclk_i);
		chk(irq, 1'b0, "masked refresh event raised interrupt");
		wait_hi(1, T + 8);
		chk(irq, 1'b1, "timeout interrupt");
		reset_len(n);
		chk(n, P + CRYSTAL_EXTRA_CYCLES, "watchdog reset length");
		chk(port_def, 1'b1, "port defaults after reset");
		rdreg(REG_STATUS, 8'h03, 8'h03, a);
		rdreg(REG_CTRL, 8'h00, 8'h0F, a);
		wrreg(REG_STATUS, 8'h07);
		repeat (2) @(negedge mclk_i);
		chk(irq, 1'b0, "interrupt after clear");
		$display("test timeout done");
		// Permanent option
		do_reset(1'b1);
		rdreg(REG_CTRL, 8'h05, 8'h05, a);
		@(posedge mclk_i);
		stop <= 1'b1;
		halt <= 1'b1;
		rdreg(REG_COUNT0, 8'h00, 8'h00, a);
		rdreg(REG_COUNT0, 8'h00, 8'h00, b);
		chk(b - a, 32'd2, "permanent count in halt and stop");
		wait_hi(1, T + 8);
		reset_len(n);
		chk(n, P + CRYSTAL_EXTRA_CYCLES, "permanent reset length");
		rdreg(REG_CTRL, 8'h05, 8'h05, a);
		$display("test permanent done");
		// Let the monitor take the last read before the verdict
		repeat (2) @(posedge mclk_i);
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
